// File: hdl/interval_counter_params.svh
// Constants for the six-mode interval counter channel
`ifndef INTERVAL_COUNTER_PARAMS_SVH
`define INTERVAL_COUNTER_PARAMS_SVH

`define COUNT_WIDTH 16
`define MODE_WIDTH 3
`define MODE_TERMINAL_INT 3'h0
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE_GEN 3'h2
`define MODE_SQUARE_WAVE 3'h3
`define MODE_SOFT_STROBE 3'h4
`define MODE_GATE_STROBE 3'h5
`define COUNT_RESET 16'h0000
`define MODE_RESET 3'h0

`endif

// File: hdl/interval_counter_pkg.sv
// Types shared by the interval counter channel and its pin synchroniser
package interval_counter_pkg;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_WAIT_TRIG = 4'h2,
    PH_COUNTING = 4'h4,
    PH_DONE = 4'h8
  } phase_t;

  typedef struct packed {
    logic mode_wr;
    logic [2:0] mode;
    logic count_wr;
    logic [15:0] count;
  } host_cmd_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
  } sync_state_t;

  typedef struct packed {
    logic [2:0] mode;
    phase_t phase;
    logic [15:0] reload;
    logic [15:0] count;
    logic out;
    logic tc;
    logic trig;
    logic clk_prev;
    logic gate_prev;
  } counter_state_t;

endpackage

// File: hdl/pin_sync.sv
// Three-stage pin synchroniser; the level follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);

  interval_counter_pkg::sync_state_t st_reg;
  interval_counter_pkg::sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.stage1 = pin_i;
    st_next.stage2 = st_reg.stage1;
    st_next.stage3 = st_reg.stage2;
    if (st_reg.stage2 == st_reg.stage3) begin
      st_next.level = st_reg.stage3;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

endmodule // pin_sync

// File: hdl/interval_counter.sv
// Down-counting interval timer channel with six setup modes
// Functional notes
// RQ1: Mode 0: output low, count while gate high
// RQ2: Mode 0: terminal count drives output high, held
// RQ3: Mode 1: low after gate edge, high on terminal
// RQ4: Mode 2: one-period low pulse every count clocks
// RQ5: Mode 3: square wave, half high half low
// RQ6: Mode 4: output high, count while gate high
// RQ7: Mode 4: terminal count gives one-clock low strobe
// RQ8: Mode 5: like mode 4, gate edge triggers
// RQ9: Mode 2: reload written count automatically at zero; the code reloads when the count is 1 and never reaches zero
// RQ10: Host writes mode first, then count value
`timescale 1ns/1ps
`include "interval_counter_params.svh"
module interval_counter (
  input wire logic clk_i,
  input wire logic reset_i,
  input interval_counter_pkg::host_cmd_t cmd_i,
  input wire logic count_clock_i,
  input wire logic gate_i,
  output logic out_o,
  output logic terminal_count_reached_o,
  output logic [15:0] count_value_o
);

  interval_counter_pkg::counter_state_t st_reg;
  interval_counter_pkg::counter_state_t st_next;
  logic clk_lvl;
  logic gate_lvl;
  logic tick;
  logic gate_rise;
  logic trig_now;
  logic no_cmd;
  logic [15:0] half_low;
  logic [15:0] half_high;

  pin_sync count_clock_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(count_clock_i),
    .level_o(clk_lvl)
  );

  pin_sync gate_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(gate_i),
    .level_o(gate_lvl)
  );

  assign tick = clk_lvl & ~st_reg.clk_prev;
  assign gate_rise = gate_lvl & ~st_reg.gate_prev;
  assign trig_now = st_reg.trig | gate_rise;
  assign no_cmd = ~cmd_i.mode_wr & ~cmd_i.count_wr;
  // Odd counts spend the extra clock in the high half
  assign half_low = st_reg.reload >> 1;
  assign half_high = st_reg.reload - half_low;

  always_comb begin
    st_next = st_reg;
    st_next.tc = 1'b0;
    st_next.clk_prev = clk_lvl;
    st_next.gate_prev = gate_lvl;
    if (cmd_i.mode_wr) begin
      st_next.mode = cmd_i.mode;
      st_next.phase = interval_counter_pkg::PH_IDLE;
      st_next.trig = 1'b0;
      st_next.out = (cmd_i.mode != `MODE_TERMINAL_INT); // RQ1 RQ6
    end else if (cmd_i.count_wr) begin
      // A count write arms or restarts the channel in its current mode
      st_next.reload = cmd_i.count; // RQ10
      st_next.trig = 1'b0;
      case (st_reg.mode)
        `MODE_ONE_SHOT, `MODE_GATE_STROBE: begin
          st_next.phase = interval_counter_pkg::PH_WAIT_TRIG;
          st_next.count = cmd_i.count;
        end
        `MODE_SQUARE_WAVE: begin
          st_next.phase = interval_counter_pkg::PH_COUNTING;
          st_next.count = cmd_i.count - (cmd_i.count >> 1);
          st_next.out = 1'b1;
        end
        default: begin
          st_next.phase = interval_counter_pkg::PH_COUNTING;
          st_next.count = cmd_i.count;
        end
      endcase
    end else begin
      if (gate_rise) begin
        st_next.trig = 1'b1;
      end
      if (tick) begin
        case (st_reg.mode)
          `MODE_TERMINAL_INT: begin
            if (st_reg.phase == interval_counter_pkg::PH_COUNTING && gate_lvl) begin // RQ1
              st_next.count = st_reg.count - 16'h0001;
              if (st_reg.count == 16'h0001) begin
                st_next.out = 1'b1; // RQ2
                st_next.tc = 1'b1;
                st_next.phase = interval_counter_pkg::PH_DONE;
              end
            end
          end
          `MODE_ONE_SHOT: begin
            if (trig_now && st_reg.phase != interval_counter_pkg::PH_IDLE) begin
              // A new gate edge retriggers from the full count
              st_next.count = st_reg.reload;
              st_next.out = 1'b0; // RQ3
              st_next.trig = 1'b0;
              st_next.phase = interval_counter_pkg::PH_COUNTING;
            end else if (st_reg.phase == interval_counter_pkg::PH_COUNTING) begin
              st_next.count = st_reg.count - 16'h0001;
              if (st_reg.count == 16'h0001) begin
                st_next.out = 1'b1; // RQ3
                st_next.tc = 1'b1;
                st_next.phase = interval_counter_pkg::PH_WAIT_TRIG;
              end
            end
          end
          `MODE_RATE_GEN: begin
            st_next.out = 1'b1;
            if (st_reg.phase == interval_counter_pkg::PH_COUNTING && gate_lvl) begin
              if (st_reg.count == 16'h0001) begin
                st_next.count = st_reg.reload; // RQ9
                st_next.out = 1'b0; // RQ4
                st_next.tc = 1'b1;
              end else begin
                st_next.count = st_reg.count - 16'h0001;
              end
            end
          end
          `MODE_SQUARE_WAVE: begin
            if (st_reg.phase == interval_counter_pkg::PH_COUNTING && gate_lvl) begin
              if (st_reg.count <= 16'h0001) begin
                st_next.out = ~st_reg.out; // RQ5
                st_next.count = st_reg.out ? half_low : half_high;
                st_next.tc = 1'b1;
              end else begin
                st_next.count = st_reg.count - 16'h0001;
              end
            end
          end
          `MODE_SOFT_STROBE, `MODE_GATE_STROBE: begin
            if (st_reg.mode == `MODE_GATE_STROBE && trig_now && st_reg.phase != interval_counter_pkg::PH_IDLE) begin
              st_next.count = st_reg.reload; // RQ8
              st_next.trig = 1'b0;
              st_next.out = 1'b1;
              st_next.phase = interval_counter_pkg::PH_COUNTING;
            end else if (st_reg.phase == interval_counter_pkg::PH_DONE) begin
              st_next.out = 1'b1; // RQ7
            end else if (st_reg.phase == interval_counter_pkg::PH_COUNTING &&
                         (gate_lvl || st_reg.mode == `MODE_GATE_STROBE)) begin // RQ6 RQ8
              st_next.count = st_reg.count - 16'h0001;
              if (st_reg.count == 16'h0001) begin
                st_next.out = 1'b0; // RQ7
                st_next.tc = 1'b1;
                st_next.phase = interval_counter_pkg::PH_DONE;
              end
            end
          end
          default: begin
            st_next.phase = interval_counter_pkg::PH_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg.mode <= `MODE_RESET;
      st_reg.phase <= interval_counter_pkg::PH_IDLE;
      st_reg.reload <= `COUNT_RESET;
      st_reg.count <= `COUNT_RESET;
      st_reg.out <= 1'b0;
      st_reg.tc <= 1'b0;
      st_reg.trig <= 1'b0;
      st_reg.clk_prev <= 1'b0;
      st_reg.gate_prev <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o = st_reg.out;
  assign terminal_count_reached_o = st_reg.tc;
  assign count_value_o = st_reg.count;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_mode0_out_low: assert property (cmd_i.mode_wr && cmd_i.mode == `MODE_TERMINAL_INT |=> !out_o) // RQ1
    else $error("mode 0 write did not drive output low");
  a_mode0_gate_hold: assert property (st_reg.mode == `MODE_TERMINAL_INT && !gate_lvl && no_cmd |=> $stable(count_value_o)) // RQ1
    else $error("mode 0 counted with gate low");
  a_mode0_tc_high: assert property (st_reg.mode == `MODE_TERMINAL_INT && out_o && !cmd_i.mode_wr |=> out_o) // RQ2
    else $error("mode 0 output left high state without mode write");
  a_mode1_trig_low: assert property (st_reg.mode == `MODE_ONE_SHOT && st_reg.phase == interval_counter_pkg::PH_WAIT_TRIG
    && trig_now && tick && no_cmd |=> !out_o ##0 count_value_o == st_reg.reload) // RQ3
    else $error("mode 1 output not low after gate trigger");
  a_mode1_tc_high: assert property (st_reg.mode == `MODE_ONE_SHOT && terminal_count_reached_o |-> out_o) // RQ3
    else $error("mode 1 output not high at terminal count");
  a_mode2_pulse_one: assert property (st_reg.mode == `MODE_RATE_GEN && !out_o && tick && no_cmd |=> out_o) // RQ4
    else $error("mode 2 low pulse longer than one count clock");
  a_mode2_reload: assert property (st_reg.mode == `MODE_RATE_GEN && terminal_count_reached_o |-> count_value_o == st_reg.reload && !out_o) // RQ9
    else $error("mode 2 did not reload the written count");
  a_mode3_toggle: assert property (st_reg.mode == `MODE_SQUARE_WAVE && st_reg.phase == interval_counter_pkg::PH_COUNTING
    && gate_lvl && tick && count_value_o <= 16'h0001 && no_cmd |=> out_o != $past(out_o)) // RQ5
    else $error("mode 3 output did not toggle at half count");
  a_mode4_init_high: assert property (cmd_i.mode_wr && cmd_i.mode == `MODE_SOFT_STROBE |=> out_o) // RQ6
    else $error("mode 4 output not high after mode write");
  // The strobe is checked in three bounded steps: low at terminal count, held low between ticks, high after the next tick
  a_strobe_tc_low: assert property ((st_reg.mode == `MODE_SOFT_STROBE || st_reg.mode == `MODE_GATE_STROBE) // RQ7
    && terminal_count_reached_o |-> !out_o)
    else $error("strobe output not low at terminal count");
  a_strobe_hold_low: assert property ((st_reg.mode == `MODE_SOFT_STROBE || st_reg.mode == `MODE_GATE_STROBE) // RQ7
    && !out_o && !tick && no_cmd |=> !out_o)
    else $error("strobe ended before the next count clock");
  a_strobe_return: assert property ((st_reg.mode == `MODE_SOFT_STROBE || st_reg.mode == `MODE_GATE_STROBE) // RQ7
    && st_reg.phase == interval_counter_pkg::PH_DONE && tick && no_cmd |=> out_o)
    else $error("strobe did not return high after one count clock");
  a_mode5_no_gate: assert property (st_reg.mode == `MODE_GATE_STROBE && st_reg.phase == interval_counter_pkg::PH_COUNTING
    && !trig_now && !gate_lvl && tick && count_value_o > 16'h0001 && no_cmd |=> count_value_o == $past(count_value_o) - 16'h0001) // RQ8
    else $error("mode 5 stopped counting with gate low");

endmodule // interval_counter

// File: sim/host_model.sv
// Host model that loads mode and count words into the counter channel
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output interval_counter_pkg::host_cmd_t cmd_o
);
  initial begin
    cmd_o = '0;
  end

  // Mode goes first so that the count write arms the freshly chosen mode
  task automatic load(input logic [2:0] mode, input logic [15:0] value);
    @(negedge clk_i);
    cmd_o = {1'b1, mode, 1'b0, ~value};
    @(negedge clk_i);
    cmd_o = {1'b0, mode, 1'b1, value};
    @(negedge clk_i);
    // Idle fields carry inverted data so a stale word cannot pass for a live one
    cmd_o = {1'b0, ~mode, 1'b0, ~value};
  endtask
endmodule // host_model

// File: sim/tb.sv
// Self-checking bench for the six-mode interval counter channel
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic count_clock_i = 1'b0;
  logic gate_i = 1'b0;
  interval_counter_pkg::host_cmd_t cmd;
  logic out_o;
  logic terminal_count_reached_o;
  logic [15:0] count_value_o;
  int fails = 0;
  int comparisons = 0;
  int tc_seen = 0;
  int tc0;
  int n;
  int highs;
  logic hist [0:15];

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (terminal_count_reached_o === 1'b1) begin
      tc_seen <= tc_seen + 1;
    end
  end

  host_model host_model_i (.clk_i(clk_i), .cmd_o(cmd));

  interval_counter interval_counter_i (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cmd_i(cmd),
    .count_clock_i(count_clock_i),
    .gate_i(gate_i),
    .out_o(out_o),
    .terminal_count_reached_o(terminal_count_reached_o),
    .count_value_o(count_value_o)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // Pin stays high and low four cycles each, enough for the three-stage synchroniser
  task automatic tick();
    @(negedge clk_i);
    count_clock_i = 1'b1;
    repeat (4) @(negedge clk_i);
    count_clock_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic set_gate(input logic v);
    @(negedge clk_i);
    gate_i = v;
    repeat (6) @(negedge clk_i);
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h370C));
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    // Rate generator with random period, two full periods
    n = $urandom_range(2, 6);
    set_gate(1'b1);
    host_model_i.load(3'h2, 16'(n));
    repeat (2) @(negedge clk_i);
    tc0 = tc_seen;
    for (int k = 1; k <= 2 * n; k++) begin
      tick();
      check(count_value_o, 16'((k % n == 0) ? n : n - k % n));
      check({15'h0000, out_o}, 16'(k % n != 0));
    end
    check(16'(tc_seen - tc0), 16'h0002);
    // Interrupt on terminal count, gate low holds the count
    n = $urandom_range(2, 6);
    set_gate(1'b0);
    host_model_i.load(3'h0, 16'(n));
    repeat (2) @(negedge clk_i);
    check({15'h0000, out_o}, 16'h0000);
    repeat (2) tick();
    check(count_value_o, 16'(n));
    set_gate(1'b1);
    for (int k = 1; k <= n + 2; k++) begin
      tick();
      check({15'h0000, out_o}, 16'(k >= n));
    end
    // Software strobe, gate low holds the count
    n = $urandom_range(2, 6);
    set_gate(1'b0);
    host_model_i.load(3'h4, 16'(n));
    repeat (2) @(negedge clk_i);
    check({15'h0000, out_o}, 16'h0001);
    repeat (2) tick();
    check(count_value_o, 16'(n));
    set_gate(1'b1);
    for (int k = 1; k <= n + 2; k++) begin
      tick();
      check({15'h0000, out_o}, 16'(k != n));
    end
    // Gate-triggered one-shot and strobe; the first tick after the edge loads the count
    for (int m = 1; m <= 5; m += 4) begin
      n = $urandom_range(2, 6);
      set_gate(1'b0);
      host_model_i.load(3'(m), 16'(n));
      tick();
      set_gate(1'b1);
      for (int k = 0; k <= n + 1; k++) begin
        tick();
        if (k == 0) begin
          check(count_value_o, 16'(n));
          if (m == 5) begin
            set_gate(1'b0);
          end
        end
        check({15'h0000, out_o}, 16'((m == 1) ? (k >= n) : (k != n)));
      end
    end
    // Square wave with an even count: half high, half low
    n = 2 * $urandom_range(2, 4);
    set_gate(1'b1);
    host_model_i.load(3'h3, 16'(n));
    repeat (2) tick();
    highs = 0;
    for (int k = 0; k < 2 * n; k++) begin
      tick();
      hist[k] = out_o;
      highs += (out_o === 1'b1) ? 1 : 0;
    end
    check(16'(highs), 16'(n));
    for (int k = n / 2; k < 2 * n; k++) begin
      check({15'h0000, hist[k]}, {15'h0000, ~hist[k - n / 2]});
    end
    complete_run();
  end
endmodule // tb
